/* ipq_regs.vh */
// Constants for the instruction prefetch queue and bus interface unit.
// Assumes inclusion by bare name from the design files of this folder.
`ifndef IPQ_REGS_VH
`define IPQ_REGS_VH
// Queue depth in bytes
`define IPQ_QUEUE_DEPTH 3'h4
// Physical address width
`define IPQ_PADDR_W 20
// Segment shift applied to the code/data base
`define IPQ_SEG_SHIFT 4
// Bus cycle length in clocks (address, wait, data)
`define IPQ_BUS_CYCLES 2'h3
// Reset values
`define IPQ_RESET_CS 16'hFFFF
`define IPQ_RESET_IP 16'h0000
`endif

/* ipq_queue.v */
// Four-byte instruction stream queue with push, pop and flush.
// Assumes one clock; flush has priority over push and pop.
`include "ipq_regs.vh"
module ipq_queue (
  input wire clock,
  input wire reset,
  input wire flush,
  input wire push,
  input wire [7:0] push_data,
  input wire pop,
  output wire [7:0] head_data,
  output wire [2:0] count,
  output wire not_empty,
  output wire has_room
);
  reg [7:0] mem_q [0:3]; // Byte store
  reg [1:0] rd_q; // Read pointer
  reg [1:0] wr_q; // Write pointer
  reg [2:0] cnt_q; // Occupancy
  wire do_pop;
  wire do_push;
  assign not_empty = (cnt_q != 3'h0);
  assign has_room = (cnt_q < `IPQ_QUEUE_DEPTH);
  assign do_pop = pop && not_empty;
  assign do_push = push && has_room;
  assign head_data = mem_q[rd_q];
  assign count = cnt_q;
  // Data store, no reset needed
  always @(posedge clock) begin
    if (do_push) begin
      mem_q[wr_q] <= push_data;
    end
  end
  // Pointers and occupancy
  always @(posedge clock) begin
    if (reset || flush) begin
      rd_q <= 2'h0;
      wr_q <= 2'h0;
      cnt_q <= 3'h0;
    end else begin
      if (do_pop) begin
        rd_q <= rd_q + 2'h1;
      end
      if (do_push) begin
        wr_q <= wr_q + 2'h1;
      end
      cnt_q <= cnt_q + {2'h0, do_push} - {2'h0, do_pop};
    end
  end
endmodule

/* ipq_bus_interface_unit.v */
// Bus interface unit: prefetch queue, data requests, 8-bit system bus.
// Assumes memory answers each cycle in fixed time; single clock domain.
//
// Contract
// - Queue holds at most four bytes
// - Prefetch only with free slot, no request
// - Branch flushes queue, refetches, hands byte over
// - Prefetch halted while data request pending
// - Running prefetch completes before data cycle
// - Queued bytes come from ascending addresses
// - Execution unit reaches bus only via requests
// - Addresses relocated into 20-bit physical space
// - External data one byte, internal sixteen bits
// - Each demand performs the requested transfer
// - Fetches addressed in code segment
// - Fetch offset advances to next byte
// - Saved offset corrected for queued bytes
// - Words: low byte at lower address
`include "ipq_regs.vh"
module ipq_bus_interface_unit (
  input wire clock,
  input wire reset,
  // Execution unit side
  input wire [15:0] code_base,
  input wire branch_req,
  input wire [15:0] branch_offset,
  input wire fetch_ready,
  output reg fetch_valid,
  output reg [7:0] fetch_byte,
  output reg [15:0] exec_offset,
  input wire xfer_req,
  input wire xfer_write,
  input wire xfer_io,
  input wire xfer_word,
  input wire [15:0] xfer_base,
  input wire [15:0] xfer_offset,
  input wire [15:0] xfer_wdata,
  output reg xfer_done,
  output reg [15:0] xfer_rdata,
  // System bus side
  output reg [19:0] bus_addr,
  output reg [7:0] bus_wdata,
  output reg bus_wdata_oe,
  input wire [7:0] bus_rdata,
  output reg bus_rd_n,
  output reg bus_wr_n,
  output reg bus_io
);
  localparam ST_IDLE = 4'b0001; // No bus cycle
  localparam ST_FETCH = 4'b0010; // Prefetch byte cycle
  localparam ST_DATA = 4'b0100; // Data byte cycle
  localparam ST_HAND = 4'b1000; // Branch byte handed over
  reg [3:0] state_q;
  reg [1:0] tick_q; // Cycle phase counter
  reg [15:0] next_fetch_offset_q; // Offset of next byte to fetch
  reg second_q; // Second byte of a word
  reg flush_pend_q; // Branch taken, target byte not yet handed over
  reg stale_q; // Fetch on the bus predates a branch
  reg [7:0] bus_rdata_s1_q; // Pin synchroniser stage one
  reg [7:0] bus_rdata_s2_q; // Pin synchroniser stage two
  wire [7:0] q_head;
  wire [2:0] q_count;
  wire q_not_empty;
  wire q_has_room;
  wire q_pop;
  wire q_push;
  wire cycle_end;
  // Segment relocation, carry above bit 19 dropped
  function [19:0] phys;
    input [15:0] base;
    input [15:0] off;
    begin
      phys = {base, 4'h0} + {4'h0, off};
    end
  endfunction
  assign cycle_end = (tick_q == (`IPQ_BUS_CYCLES - 2'h1));
  assign q_push = (state_q == ST_FETCH) && cycle_end && !flush_pend_q
    && !branch_req;
  assign q_pop = fetch_ready && q_not_empty && (state_q != ST_HAND);
  // Queue instance; a branch discards its contents
  ipq_queue u_queue (
    .clock(clock),
    .reset(reset),
    .flush(branch_req),
    .push(q_push),
    .push_data(bus_rdata_s2_q),
    .pop(q_pop),
    .head_data(q_head),
    .count(q_count),
    .not_empty(q_not_empty),
    .has_room(q_has_room)
  );
  // Read data pins pass two flops before use
  always @(posedge clock) begin
    bus_rdata_s1_q <= bus_rdata;
    bus_rdata_s2_q <= bus_rdata_s1_q;
  end
  // Instruction byte output to the execution unit
  always @(posedge clock) begin
    if (reset || branch_req) begin
      fetch_valid <= 1'b0;
      fetch_byte <= 8'h00;
    end else if (state_q == ST_FETCH && cycle_end && flush_pend_q
      && !stale_q) begin
      // Byte at the branch target goes straight through
      fetch_valid <= 1'b1;
      fetch_byte <= bus_rdata_s2_q;
    end else if (q_pop) begin
      fetch_valid <= 1'b1;
      fetch_byte <= q_head;
    end else if (fetch_ready) begin
      fetch_valid <= 1'b0;
    end
  end
  // Offset of the next instruction to execute
  always @(posedge clock) begin
    if (reset) begin
      exec_offset <= `IPQ_RESET_IP;
    end else begin
      // Fetch offset less the bytes still waiting in the queue
      exec_offset <= next_fetch_offset_q - {13'h0000, q_count};
    end
  end
  // Bus sequencer, fetch offset and data transfer
  always @(posedge clock) begin
    if (reset) begin
      state_q <= ST_IDLE;
      tick_q <= 2'h0;
      next_fetch_offset_q <= `IPQ_RESET_IP;
      second_q <= 1'b0;
      flush_pend_q <= 1'b0;
      stale_q <= 1'b0;
      xfer_done <= 1'b0;
      xfer_rdata <= 16'h0000;
      bus_addr <= 20'h00000;
      bus_wdata <= 8'h00;
      bus_wdata_oe <= 1'b0;
      bus_rd_n <= 1'b1;
      bus_wr_n <= 1'b1;
      bus_io <= 1'b0;
    end else begin
      xfer_done <= 1'b0;
      if (branch_req) begin
        next_fetch_offset_q <= branch_offset;
        flush_pend_q <= 1'b1;
        // A fetch already on the bus now carries an old byte
        if (state_q == ST_FETCH && !cycle_end) begin
          stale_q <= 1'b1;
        end
      end
      case (state_q)
        ST_IDLE: begin
          tick_q <= 2'h0;
          // Request still seen in the done cycle is not taken again
          if (xfer_req && !xfer_done) begin
            // Data request wins over prefetch
            state_q <= ST_DATA;
            bus_addr <= phys(xfer_base, xfer_offset + {15'h0000, second_q});
            bus_io <= xfer_io;
            bus_rd_n <= xfer_write;
            bus_wr_n <= !xfer_write;
            bus_wdata_oe <= xfer_write;
            // Low byte first at the lower address
            bus_wdata <= second_q ? xfer_wdata[15:8] : xfer_wdata[7:0];
          end else if (!xfer_req
            && (q_has_room || flush_pend_q || branch_req)) begin
            state_q <= ST_FETCH;
            bus_addr <= phys(code_base, branch_req ? branch_offset
              : next_fetch_offset_q);
            bus_io <= 1'b0;
            bus_rd_n <= 1'b0;
            bus_wr_n <= 1'b1;
          end
        end
        ST_FETCH: begin
          tick_q <= tick_q + 2'h1;
          if (cycle_end) begin
            // Finishes even if a data request arrived meanwhile
            state_q <= ST_IDLE;
            tick_q <= 2'h0;
            bus_rd_n <= 1'b1;
            stale_q <= 1'b0;
            // A stale byte is dropped; the target is fetched next
            if (!branch_req && !stale_q) begin
              next_fetch_offset_q <= next_fetch_offset_q + 16'h0001;
              flush_pend_q <= 1'b0;
              if (flush_pend_q) begin
                state_q <= ST_HAND;
              end
            end
          end
        end
        ST_DATA: begin
          tick_q <= tick_q + 2'h1;
          if (cycle_end) begin
            tick_q <= 2'h0;
            bus_rd_n <= 1'b1;
            bus_wr_n <= 1'b1;
            bus_wdata_oe <= 1'b0;
            state_q <= ST_IDLE;
            // Assemble sixteen bits from two byte cycles
            if (second_q) begin
              xfer_rdata[15:8] <= bus_rdata_s2_q;
            end else begin
              xfer_rdata[7:0] <= bus_rdata_s2_q;
              xfer_rdata[15:8] <= 8'h00;
            end
            if (xfer_word && !second_q) begin
              second_q <= 1'b1;
            end else begin
              second_q <= 1'b0;
              xfer_done <= 1'b1;
            end
          end
        end
        ST_HAND: begin
          // Wait for the handed byte to be taken, then refill
          if (!fetch_valid || fetch_ready || branch_req) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

/* ipq_mem_model.sv */
// Memory and I/O stand-in for the system bus side.
// Assumes active low strobes; reads answer from the address at once.
module ipq_mem_model (
  input wire logic clock,
  input wire logic [19:0] bus_addr,
  input wire logic bus_rd_n,
  output logic [7:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] idle_q = 8'h00; // Junk that changes while nobody reads
  // Stir the idle pattern every clock
  always @(posedge clock) idle_q <= idle_q + 8'h35;
  // Data stands for the whole strobe, junk otherwise
  assign bus_rdata = bus_rd_n ? idle_q : bus_addr[7:0] ^ bus_addr[19:12];
endmodule

/* ipq_props.sv */
// Checker for the bus interface unit ports.
// Assumes one clock and a synchronous active high reset.
module ipq_props (
  input wire clock,
  input wire reset,
  input wire branch_req,
  input wire fetch_ready,
  input wire fetch_valid,
  input wire [7:0] fetch_byte,
  input wire xfer_req,
  input wire xfer_write,
  input wire xfer_io,
  input wire xfer_word,
  input wire xfer_done,
  input wire [15:0] xfer_rdata,
  input wire bus_wdata_oe,
  input wire bus_rd_n,
  input wire bus_wr_n,
  input wire bus_io
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_rd_len; $fell(bus_rd_n) |-> !bus_rd_n[*3]; endproperty
  a_rd_len: assert property (p_rd_len) else $error("short read");
  property p_wr_len;
    $fell(bus_wr_n) |-> (!bus_wr_n && bus_wdata_oe)[*3];
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("bad write");
  property p_wr_src; !bus_wr_n |-> xfer_req && xfer_write; endproperty
  a_wr_src: assert property (p_wr_src) else $error("stray write");
  property p_io_src;
    !(bus_rd_n && bus_wr_n) && bus_io |-> xfer_req && xfer_io;
  endproperty
  a_io_src: assert property (p_io_src) else $error("stray io");
  property p_done; xfer_done |-> $past(xfer_req) ##1 !xfer_done; endproperty
  a_done: assert property (p_done) else $error("bad done");
  property p_zext;
    xfer_done && !xfer_word && !xfer_write |-> xfer_rdata[15:8] == 8'h00;
  endproperty
  a_zext: assert property (p_zext) else $error("no zero fill");
  property p_flush; branch_req |=> !fetch_valid; endproperty
  a_flush: assert property (p_flush) else $error("no flush");
  property p_hold;
    fetch_valid && !fetch_ready && !branch_req |=>
      fetch_valid && $stable(fetch_byte);
  endproperty
  a_hold: assert property (p_hold) else $error("byte lost");
endmodule
bind ipq_bus_interface_unit ipq_props u_props (
  .clock(clock),
  .reset(reset),
  .branch_req(branch_req),
  .fetch_ready(fetch_ready),
  .fetch_valid(fetch_valid),
  .fetch_byte(fetch_byte),
  .xfer_req(xfer_req),
  .xfer_write(xfer_write),
  .xfer_io(xfer_io),
  .xfer_word(xfer_word),
  .xfer_done(xfer_done),
  .xfer_rdata(xfer_rdata),
  .bus_wdata_oe(bus_wdata_oe),
  .bus_rd_n(bus_rd_n),
  .bus_wr_n(bus_wr_n),
  .bus_io(bus_io)
);

/* testbench.sv */
// Bench for the bus interface unit: prefetch, branch, data transfers.
// Assumes the memory model answers as soon as a strobe falls.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, reset, branch_req, fetch_ready, fetch_valid, xfer_req;
  logic xfer_write, xfer_io, xfer_word, xfer_done, bus_wdata_oe;
  logic bus_rd_n, bus_wr_n, bus_io;
  logic [15:0] code_base, branch_offset, exec_offset, xfer_base;
  logic [15:0] xfer_offset, xfer_wdata, xfer_rdata;
  logic [7:0] fetch_byte, bus_wdata, bus_rdata;
  logic [19:0] bus_addr;
  int errors, samples_checked, cycles;
  ipq_bus_interface_unit dut (
    .clock(clock), .reset(reset), .code_base(code_base),
    .branch_req(branch_req), .branch_offset(branch_offset),
    .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
    .fetch_byte(fetch_byte), .exec_offset(exec_offset),
    .xfer_req(xfer_req), .xfer_write(xfer_write), .xfer_io(xfer_io),
    .xfer_word(xfer_word), .xfer_base(xfer_base),
    .xfer_offset(xfer_offset), .xfer_wdata(xfer_wdata),
    .xfer_done(xfer_done), .xfer_rdata(xfer_rdata),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wdata_oe(bus_wdata_oe), .bus_rdata(bus_rdata),
    .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .bus_io(bus_io)
  );
  ipq_mem_model mem (
    .clock(clock), .bus_addr(bus_addr), .bus_rd_n(bus_rd_n),
    .bus_rdata(bus_rdata)
  );
  // Byte that the memory model holds at an address
  function automatic logic [7:0] md(input logic [19:0] a);
    return a[7:0] ^ a[19:12];
  endfunction
  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Take n bytes, expected from ascending addresses from p
  task automatic take(input int n, input logic [19:0] p);
    int k;
    k = 0;
    fetch_ready <= 1'b1;
    for (int t = 0; t < 400 && k < n; t++) begin
      @(posedge clock);
      if (fetch_valid === 1'b1) begin
        cmp(fetch_byte, md(p + 20'(k)));
        k++;
      end
    end
    cmp(20'(k), 20'(n));
    fetch_ready <= 1'b0;
  endtask
  // Branch, check the handed byte, then count refills with no consumer
  task automatic branch_stall();
    int n;
    logic p;
    n = 0;
    @(posedge clock);
    branch_req <= 1'b1;
    branch_offset <= 16'h0012;
    @(posedge clock);
    branch_req <= 1'b0;
    repeat (30) @(posedge clock);
    cmp(fetch_valid, 1'b1);
    cmp(fetch_byte, md(20'h0_0002));
    cmp(bus_rd_n, 1'b1);
    fetch_ready <= 1'b1;
    @(posedge clock);
    fetch_ready <= 1'b0;
    p = 1'b1;
    repeat (60) begin
      @(posedge clock);
      if (bus_rd_n === 1'b0 && p) n++;
      p = bus_rd_n;
    end
    cmp(20'(n), 20'h4);
    cmp(bus_rd_n, 1'b1);
    cmp(fetch_valid, 1'b0);
    cmp(exec_offset, 16'h0013);
  endtask
  // One data transfer while prefetch runs; c is word, io, write
  task automatic xfer(input logic [2:0] c);
    logic [19:0] a, q[$];
    logic p, s;
    a = 20'h1_243F;
    p = 1'b0;
    fetch_ready <= 1'b1;
    {xfer_word, xfer_io, xfer_write} <= c;
    xfer_req <= 1'b1;
    for (int t = 0; t < 60 && xfer_done !== 1'b1; t++) begin
      @(posedge clock);
      s = !(bus_rd_n && bus_wr_n);
      if (s && !p && (bus_addr == a || bus_addr == a + 1)) begin
        cmp({bus_io, bus_wr_n}, {c[1], !c[0]});
        if (c[0]) cmp(bus_wdata, bus_addr == a ? 8'h5A : 8'hA5);
      end
      if (s && !p) q.push_back(bus_addr);
      p = s;
    end
    xfer_req <= 1'b0;
    fetch_ready <= 1'b0;
    cmp(xfer_done, 1'b1);
    if (!c[0]) cmp(xfer_rdata, {c[2] ? md(a + 1) : 8'h00, md(a)});
    if (q.size() > 1 && q[0] != a) q.pop_front();
    cmp(20'(q.size()), 20'(c[2] + 1));
    cmp(q[0], a);
    if (c[2]) cmp(q[1], a + 1);
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Cut a hang short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      results();
    end
  end
  initial begin
    {branch_req, fetch_ready, xfer_req, xfer_write, xfer_io} = '0;
    {xfer_word, branch_offset} = '0;
    {code_base, xfer_base, xfer_offset} = {16'hFFFF, 16'h1234, 16'h00FF};
    xfer_wdata = 16'hA55A;
    reset = 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    take(6, 20'hF_FFF0);
    branch_stall();
    take(4, 20'h0_0003);
    for (int c = 0; c < 8; c++) begin
      repeat (2) @(posedge clock);
      xfer(3'(c));
    end
    results();
  end
endmodule
